/* sdram_cmd_map.vh */
// How it works
// - Clock enable is sampled each edge; previous and current levels pick transition.
// - Legality and action use the state before the edge and registered command.
// - Enable falling: idle+NOP power-down, idle+refresh self refresh, burst suspends.
// - Power-down exit with NOP reaches all-banks-idle by the next edge.
// - Self refresh exit reaches all-banks-idle after the exit time.
// - Suspend exit at edge n; next command is taken at edge n plus one.
// - Chip select high is inhibit; low with all strobes high is NOP.
// - Strobes decode to terminate, precharge, refresh, mode load, read, write, active.
// - Idle bank takes active, refresh, mode load, precharge; precharge acts as NOP.
// - Row-active bank takes read, write, and precharge of one or all banks.
// - Read burst takes read, write, terminate, or precharge that cuts it short.
// - Write burst takes read, write, terminate, or precharge that cuts it short.
// - Burst terminate acts on the latest burst unless it has auto precharge, whatever bank is addressed.
// - Reads and writes are taken with and without auto precharge alike.
// - Idle after precharge period; row active after activate delay, no access.
// - Bank goes idle after precharge period; row active after activate delay.
// - All idle after refresh cycle, mode load delay, or precharge-all period.
// - In suspend every edge up to the exit edge freezes commands, bank states and burst counters.
`ifndef SDRAM_CMD_MAP_VH
`define SDRAM_CMD_MAP_VH

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS         100
`define PRECHARGE_PERIOD_NS   20
`define ACT_TO_ACCESS_NS      20
`define REFRESH_CYCLE_NS      70
`define MODE_LOAD_NS          20
`define SR_EXIT_NS            80
`define NS_TO_CYC(t) (((t)+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define PRECHARGE_CYC  `NS_TO_CYC(`PRECHARGE_PERIOD_NS)
`define ACT_TO_ACC_CYC `NS_TO_CYC(`ACT_TO_ACCESS_NS)
`define REFRESH_CYC    `NS_TO_CYC(`REFRESH_CYCLE_NS)
`define MODE_LOAD_CYC  `NS_TO_CYC(`MODE_LOAD_NS)
`define SR_EXIT_CYC    `NS_TO_CYC(`SR_EXIT_NS)

// ----------------------------------------
// Strobe codes {row, column, write}
// ----------------------------------------
`define CMD_NOP      3'h7
`define CMD_ACTIVE   3'h3
`define CMD_READ     3'h5
`define CMD_WRITE    3'h4
`define CMD_TERM     3'h6
`define CMD_PRE      3'h2
`define CMD_REFRESH  3'h1
`define CMD_LOADMODE 3'h0

// ----------------------------------------
// Bank states
// ----------------------------------------
`define BK_IDLE      3'h0
`define BK_ACTIVATE  3'h1
`define BK_ACTIVE    3'h2
`define BK_READ      3'h3
`define BK_WRITE     3'h4
`define BK_READ_AP   3'h5
`define BK_WRITE_AP  3'h6
`define BK_PRECHARGE 3'h7

// ----------------------------------------
// Global states
// ----------------------------------------
`define GS_NORMAL    3'h0
`define GS_REFRESH   3'h1
`define GS_MODELOAD  3'h2
`define GS_PRE_ALL   3'h3
`define GS_PWRDOWN   3'h4
`define GS_SELFREF   3'h5
`define GS_SR_EXIT   3'h6
`define GS_SUSPEND   3'h7

`endif

/* sdram_state_command_decoder.v */
`timescale 1ns/1ps
`include "sdram_cmd_map.vh"

module sdram_state_command_decoder #(
   parameter BURST_LEN = 4,
   parameter TIMER_W   = 4
) (
   input  wire        clock,
   input  wire        sys_rst,
   input  wire        cke,
   input  wire        cs_n,
   input  wire        ras_n,
   input  wire        cas_n,
   input  wire        we_n,
   input  wire [1:0]  ba,
   input  wire        a10,
   output wire [11:0] bank_state,
   output reg  [2:0]  global_state,
   output reg         all_banks_idle,
   output reg         cmd_accepted,
   output reg         cmd_refused,
   output reg         internal_clock_run,
   output reg         burst_running,
   output reg  [1:0]  burst_bank
);

// ----------------------------------------
// Timer loads
// ----------------------------------------
// Full-width counts, cut to the timer width below; the burst count is cut to 8 bits
localparam [31:0]        N_PRE    = `PRECHARGE_CYC - 1;
localparam [31:0]        N_ACT    = `ACT_TO_ACC_CYC - 1;
localparam [31:0]        N_REF    = `REFRESH_CYC - 1;
localparam [31:0]        N_MODE   = `MODE_LOAD_CYC - 1;
localparam [31:0]        N_SRX    = `SR_EXIT_CYC - 1;
localparam [31:0]        N_BURST  = BURST_LEN - 1;
localparam [TIMER_W-1:0] LD_PRE   = N_PRE[TIMER_W-1:0];
localparam [TIMER_W-1:0] LD_ACT   = N_ACT[TIMER_W-1:0];
localparam [TIMER_W-1:0] LD_REF   = N_REF[TIMER_W-1:0];
localparam [TIMER_W-1:0] LD_MODE  = N_MODE[TIMER_W-1:0];
localparam [TIMER_W-1:0] LD_SRX   = N_SRX[TIMER_W-1:0];
localparam [7:0]         LD_BURST = N_BURST[7:0];

// ----------------------------------------
// Registered pins
// ----------------------------------------
// Pins come from the controller on this clock; no synchroniser
reg       cke_now;
reg       cke_prev;
reg       cs_r;
reg [2:0] code_r;
reg [1:0] ba_r;
reg       a10_r;

// Command registered at the edge
always @(posedge clock or posedge sys_rst) begin
   if (sys_rst) begin
      cke_now  <= 1'b1;
      cke_prev <= 1'b1;
      cs_r     <= 1'b1;
      code_r   <= `CMD_NOP;
      ba_r     <= 2'h0;
      a10_r    <= 1'b0;
   end else begin
      cke_prev <= cke_now;
      cke_now  <= cke;
      cs_r     <= cs_n;
      code_r   <= {ras_n, cas_n, we_n};
      ba_r     <= ba;
      a10_r    <= a10;
   end
end

// ----------------------------------------
// Decode
// ----------------------------------------
wire       nopish  = cs_r | (code_r == `CMD_NOP);
wire       c_act   = !cs_r && code_r == `CMD_ACTIVE;
wire       c_rd    = !cs_r && code_r == `CMD_READ;
wire       c_wr    = !cs_r && code_r == `CMD_WRITE;
wire       c_term  = !cs_r && code_r == `CMD_TERM;
wire       c_pre   = !cs_r && code_r == `CMD_PRE;
wire       c_ref   = !cs_r && code_r == `CMD_REFRESH;
wire       c_mode  = !cs_r && code_r == `CMD_LOADMODE;

// Current bank states seen by the central logic
wire [2:0] st0 = bank_state[2:0];
wire [2:0] st1 = bank_state[5:3];
wire [2:0] st2 = bank_state[8:6];
wire [2:0] st3 = bank_state[11:9];
wire [2:0] tgt = bank_state[3*ba_r +: 3];
wire [2:0] bst = bank_state[3*burst_bank +: 3];

// Bank may be precharged from this state
function pre_ok;
   input [2:0] s;
   begin
      pre_ok = s == `BK_IDLE || s == `BK_ACTIVE ||
               s == `BK_READ || s == `BK_WRITE;
   end
endfunction

// Whole-device and target-bank views of the bank states
wire idle_all = st0 == `BK_IDLE && st1 == `BK_IDLE &&
                st2 == `BK_IDLE && st3 == `BK_IDLE;
wire pre_all_ok = pre_ok(st0) && pre_ok(st1) &&
                  pre_ok(st2) && pre_ok(st3);
wire tgt_open = tgt == `BK_ACTIVE || tgt == `BK_READ ||
                tgt == `BK_WRITE;

// ----------------------------------------
// Legality per command
// ----------------------------------------
// Activate, read, write, single precharge: target bank; terminate: burst bank; others: all banks
wire ok_act  = c_act && tgt == `BK_IDLE;
wire ok_rw   = (c_rd || c_wr) && tgt_open;
wire ok_term = c_term && burst_running &&
               (bst == `BK_READ || bst == `BK_WRITE);
wire ok_pre1 = c_pre && !a10_r && pre_ok(tgt);
wire ok_preA = c_pre && a10_r && pre_all_ok;
wire ok_ref  = c_ref && idle_all;
wire ok_mode = c_mode && idle_all;

// Enable history qualifies every decision
wire normal  = global_state == `GS_NORMAL;
wire run_hh  = normal && cke_prev && cke_now;
wire fall    = normal && cke_prev && !cke_now;
wire sus_wr  = fall && burst_running && c_wr && ok_rw;

// Bank actions taken at this edge
wire do_act  = run_hh && ok_act;
wire do_rw   = (run_hh && ok_rw) || sus_wr;
wire do_term = run_hh && ok_term;
wire do_pre1 = run_hh && ok_pre1;
wire do_preA = run_hh && ok_preA;
wire freeze  = global_state == `GS_SUSPEND;

// Beats left in the latest burst
reg [7:0] burst_cnt;

// Latest burst ends without a new one replacing it
wire burst_last = burst_running && burst_cnt == 8'h00;
wire burst_cut  = do_term ||
                  (do_pre1 && ba_r == burst_bank) || do_preA;

// ----------------------------------------
// Burst tracker
// ----------------------------------------
// Most recent read or write burst
always @(posedge clock or posedge sys_rst) begin
   if (sys_rst) begin
      burst_running <= 1'b0;
      burst_bank    <= 2'h0;
      burst_cnt     <= 8'h00;
   end else if (freeze) begin
      burst_cnt <= burst_cnt;
   end else if (do_rw) begin
      burst_running <= 1'b1;
      burst_bank    <= ba_r;
      burst_cnt     <= LD_BURST;
   end else if (burst_running) begin
      if (burst_cut || burst_last)
         burst_running <= 1'b0;
      else
         burst_cnt <= burst_cnt - 8'h01;
   end
end

// ----------------------------------------
// Per-bank state machines
// ----------------------------------------
genvar i;
generate
   for (i = 0; i < 4; i = i + 1) begin : bank
      reg [2:0]         state;
      reg [TIMER_W-1:0] timer;
      wire mine  = ba_r == i;
      wire owner = burst_running && burst_bank == i;
      // Own burst ends: done, cut, or taken over by another bank
      wire ends  = owner && (burst_last || do_term ||
                   (do_rw && !mine));
      wire pre_me = (do_pre1 && mine) || do_preA;

      assign bank_state[3*i +: 3] = state;

      // Bank state and delay timer
      always @(posedge clock or posedge sys_rst) begin
         if (sys_rst) begin
            state <= `BK_IDLE;
            timer <= {TIMER_W{1'b0}};
         end else if (!freeze) begin
            case (state)
               `BK_IDLE: begin
                  if (do_act && mine) begin
                     state <= `BK_ACTIVATE;
                     timer <= LD_ACT;
                  end
               end
               `BK_ACTIVATE: begin
                  if (timer == {TIMER_W{1'b0}})
                     state <= `BK_ACTIVE;
                  else
                     timer <= timer - 1'b1;
               end
               `BK_PRECHARGE: begin
                  if (timer == {TIMER_W{1'b0}})
                     state <= `BK_IDLE;
                  else
                     timer <= timer - 1'b1;
               end
               `BK_READ_AP, `BK_WRITE_AP: begin
                  if (ends) begin
                     state <= `BK_PRECHARGE;
                     timer <= LD_PRE;
                  end
               end
               default: begin // Row active, read, write
                  if (pre_me) begin
                     state <= `BK_PRECHARGE;
                     timer <= LD_PRE;
                  end else if (do_rw && mine) begin
                     if (c_rd)
                        state <= a10_r ? `BK_READ_AP : `BK_READ;
                     else
                        state <= a10_r ? `BK_WRITE_AP : `BK_WRITE;
                  end else if (ends) begin
                     state <= `BK_ACTIVE;
                  end
               end
            endcase
         end
      end
   end
endgenerate

// ----------------------------------------
// Global state machine
// ----------------------------------------
reg [TIMER_W-1:0] gtimer;
reg [2:0]         next_global;
reg [TIMER_W-1:0] next_gtimer;
reg               next_ok;
reg               next_bad;

// Timer at zero marks the last cycle of a timed global state
wire gdone = gtimer == {TIMER_W{1'b0}};
wire bank_ok = ok_act || ok_rw || ok_term || ok_pre1 || ok_preA;

// Enable history plus command pick the next global state
always @* begin
   next_global = global_state;
   next_gtimer = gtimer;
   next_ok     = 1'b0;
   next_bad    = 1'b0;
   case (global_state)
      `GS_NORMAL: begin
         if (!cke_prev) begin
            next_ok = nopish;
         end else if (cke_now) begin
            if (nopish) begin
               next_ok = 1'b1;
            end else if (ok_ref) begin
               next_global = `GS_REFRESH;
               next_gtimer = LD_REF;
               next_ok     = 1'b1;
            end else if (ok_mode) begin
               next_global = `GS_MODELOAD;
               next_gtimer = LD_MODE;
               next_ok     = 1'b1;
            end else if (ok_preA) begin
               next_global = `GS_PRE_ALL;
               next_gtimer = LD_PRE;
               next_ok     = 1'b1;
            end else begin
               next_ok  = bank_ok;
               next_bad = !bank_ok;
            end
         end else if (idle_all && nopish) begin
            next_global = `GS_PWRDOWN;
            next_ok     = 1'b1;
         end else if (idle_all && ok_ref) begin
            next_global = `GS_SELFREF;
            next_ok     = 1'b1;
         end else if (burst_running && (nopish || sus_wr)) begin
            next_global = `GS_SUSPEND;
            next_ok     = 1'b1;
         end else begin
            next_bad = 1'b1;
         end
      end
      `GS_REFRESH, `GS_MODELOAD, `GS_PRE_ALL: begin
         next_bad = !nopish;
         if (gdone)
            next_global = `GS_NORMAL;
         else
            next_gtimer = gtimer - 1'b1;
      end
      `GS_PWRDOWN: begin
         if (cke_now && !cke_prev && nopish) begin
            next_global = `GS_NORMAL;
            next_ok     = 1'b1;
         end
      end
      `GS_SELFREF: begin
         if (cke_now && !cke_prev && nopish) begin
            next_global = `GS_SR_EXIT;
            next_gtimer = LD_SRX;
            next_ok     = 1'b1;
         end
      end
      `GS_SR_EXIT: begin
         next_bad = !nopish;
         if (gdone)
            next_global = `GS_NORMAL;
         else
            next_gtimer = gtimer - 1'b1;
      end
      default: begin // Clock suspend
         if (cke_now)
            next_global = `GS_NORMAL;
      end
   endcase
end

// Global state register and status pulses
always @(posedge clock or posedge sys_rst) begin
   if (sys_rst) begin
      global_state       <= `GS_NORMAL;
      gtimer             <= {TIMER_W{1'b0}};
      cmd_accepted       <= 1'b0;
      cmd_refused        <= 1'b0;
      all_banks_idle     <= 1'b1;
      internal_clock_run <= 1'b1;
   end else begin
      global_state       <= next_global;
      gtimer             <= next_gtimer;
      cmd_accepted       <= next_ok;
      cmd_refused        <= next_bad;
      all_banks_idle     <= idle_all && normal;
      internal_clock_run <= next_global != `GS_SUSPEND;
   end
end

endmodule // sdram_state_command_decoder

/* sdram_decoder_asserts.sv */
`timescale 1ns/1ps
`include "sdram_cmd_map.vh"

module sdram_decoder_asserts #(
   parameter BURST_LEN = 4,
   parameter TIMER_W   = 4
) (
   input wire        clock,
   input wire        sys_rst,
   input wire        cke,
   input wire        cs_n,
   input wire        ras_n,
   input wire        cas_n,
   input wire        we_n,
   input wire [1:0]  ba,
   input wire        a10,
   input wire [11:0] bank_state,
   input wire [2:0]  global_state,
   input wire        all_banks_idle,
   input wire        cmd_accepted,
   input wire        cmd_refused,
   input wire        internal_clock_run,
   input wire        burst_running,
   input wire [1:0]  burst_bank
);
   // Strobes as one code
   wire [2:0] cmd;
   assign cmd = {ras_n, cas_n, we_n};

   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_inhibit_quiet: assert property (cs_n && cke && $past(cke)
      |-> ##2 !cmd_refused) else $error("inhibit refused");
   a_suspend_stops: assert property (global_state == `GS_SUSPEND
      |-> !internal_clock_run ##1 ($stable(bank_state)
      && $stable(burst_running))) else $error("clock runs in suspend");
   a_activate_time: assert property (bank_state[2:0] == `BK_ACTIVATE
      && internal_clock_run |=> bank_state[2:0] == `BK_ACTIVE)
      else $error("activate delay wrong");
   a_precharge_time: assert property (bank_state[2:0] == `BK_PRECHARGE
      && internal_clock_run |=> bank_state[2:0] == `BK_IDLE)
      else $error("precharge period wrong");
   a_global_time: assert property (global_state inside {`GS_REFRESH,
      `GS_MODELOAD, `GS_PRE_ALL, `GS_SR_EXIT} |=> global_state == `GS_NORMAL)
      else $error("global delay wrong");
   a_active_taken: assert property ((!cs_n && cmd == `CMD_ACTIVE
      && ba == 2'h0 && cke && $past(cke)) ##1 (bank_state[2:0] == `BK_IDLE
      && global_state == `GS_NORMAL) |=> (bank_state[2:0] == `BK_ACTIVATE
      && cmd_accepted)) else $error("active not taken");
   a_term_latest: assert property ((!cs_n && cmd == `CMD_TERM && cke
      && $past(cke)) ##1 (burst_running && (bank_state[burst_bank*3 +: 3]
      inside {`BK_READ, `BK_WRITE})) |=> !burst_running)
      else $error("terminate missed burst");
   a_pd_entry: assert property ((!cke && $past(cke) && (cs_n
      || cmd == `CMD_NOP)) ##1 (bank_state == 12'h000
      && global_state == `GS_NORMAL) |=> global_state == `GS_PWRDOWN)
      else $error("no power-down entry");
   a_pd_hold: assert property (global_state == `GS_PWRDOWN && !cke
      && !$past(cke) |-> ##2 global_state == `GS_PWRDOWN)
      else $error("power-down left");
   a_pd_exit: assert property (global_state == `GS_PWRDOWN && cke
      && !$past(cke) && (cs_n || cmd == `CMD_NOP)
      |-> ##2 global_state == `GS_NORMAL) else $error("no power-down exit");

   // Main scenarios
   c_pwrdown: cover property (global_state == `GS_PWRDOWN);
   c_selfref: cover property (global_state == `GS_SELFREF);
   c_suspend: cover property (global_state == `GS_SUSPEND);
   c_term: cover property ($fell(burst_running));
endmodule // sdram_decoder_asserts

bind sdram_state_command_decoder sdram_decoder_asserts #(
   .BURST_LEN(BURST_LEN), .TIMER_W(TIMER_W)) sdram_decoder_asserts_i (
   .clock(clock), .sys_rst(sys_rst), .cke(cke), .cs_n(cs_n),
   .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10),
   .bank_state(bank_state), .global_state(global_state),
   .all_banks_idle(all_banks_idle), .cmd_accepted(cmd_accepted),
   .cmd_refused(cmd_refused), .internal_clock_run(internal_clock_run),
   .burst_running(burst_running), .burst_bank(burst_bank));

/* sdram_ctrl_model.sv */
`timescale 1ns/1ps
`include "sdram_cmd_map.vh"

module sdram_ctrl_model (
   input  wire       req,
   input  wire [2:0] req_cmd,
   input  wire [1:0] req_ba,
   input  wire       req_a10,
   input  wire       req_cke,
   input  wire       idle_inhibit,
   output wire       cke,
   output wire       cs_n,
   output wire       ras_n,
   output wire       cas_n,
   output wire       we_n,
   output wire [1:0] ba,
   output wire       a10
);
   // Between requests only inhibit or NOP is sent
   assign cs_n = req ? 1'b0 : idle_inhibit;
   assign {ras_n, cas_n, we_n} = req ? req_cmd : `CMD_NOP;
   assign ba = req_ba;
   assign a10 = req_a10;
   // Level held by the bench, kept short in power-down
   assign cke = req_cke;
endmodule // sdram_ctrl_model

/* tb_top.sv */
`timescale 1ns/1ps
`include "sdram_cmd_map.vh"

module tb_top;
   reg         clock = 1'b0;
   reg         sys_rst = 1'b1;
   reg         req = 1'b0;
   reg  [2:0]  req_cmd = `CMD_NOP;
   reg  [1:0]  req_ba = 2'h0;
   reg         req_a10 = 1'b0;
   reg         req_cke = 1'b1;
   reg         idle_inhibit = 1'b0;
   wire        cke, cs_n, ras_n, cas_n, we_n, a10;
   wire [1:0]  ba, burst_bank;
   wire [11:0] bank_state;
   wire [2:0]  global_state;
   wire        all_banks_idle, cmd_accepted, cmd_refused;
   wire        internal_clock_run, burst_running;
   integer     bad_count = 0;
   integer     n_compared = 0;
   integer     cyc = 0;

   sdram_ctrl_model sdram_ctrl_model_i (.req(req), .req_cmd(req_cmd),
      .req_ba(req_ba), .req_a10(req_a10), .req_cke(req_cke),
      .idle_inhibit(idle_inhibit), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .ba(ba), .a10(a10));

   sdram_state_command_decoder #(.BURST_LEN(4), .TIMER_W(4))
      sdram_state_command_decoder_i (.clock(clock), .sys_rst(sys_rst),
      .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
      .ba(ba), .a10(a10), .bank_state(bank_state),
      .global_state(global_state), .all_banks_idle(all_banks_idle),
      .cmd_accepted(cmd_accepted), .cmd_refused(cmd_refused),
      .internal_clock_run(internal_clock_run),
      .burst_running(burst_running), .burst_bank(burst_bank));

   // ----------------------------------------
   // Clock and hang guard
   // ----------------------------------------
   always #50 clock = ~clock;

   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 3000) begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task tally_and_finish;
      begin
         $display("compared %0d mismatched %0d", n_compared, bad_count);
         if (bad_count == 0 && n_compared > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask

   task chk(input [8*8:1] nm, input [11:0] e, input [11:0] g);
      begin
         n_compared = n_compared + 1;
         if (g !== e) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
         end
      end
   endtask

   // One command, returns when its outcome is visible
   task issue(input [2:0] c, input [1:0] b, input a, input k);
      begin
         @(negedge clock);
         req = 1'b1;
         req_cmd = c;
         req_ba = b;
         req_a10 = a;
         req_cke = k;
         @(negedge clock);
         req = 1'b0;
         @(negedge clock);
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_row;
      begin
         idle_inhibit = 1'b1;
         issue(`CMD_ACTIVE, 2'h1, 1'b0, 1'b1);
         chk("banks", 12'h008, bank_state);
         chk("accept", 12'h001, {11'h000, cmd_accepted});
         @(negedge clock);
         chk("banks", 12'h010, bank_state);
         issue(`CMD_READ, 2'h1, 1'b0, 1'b1);
         chk("banks", 12'h018, bank_state);
         chk("burst", 12'h005, {9'h000, burst_running, burst_bank});
         issue(`CMD_TERM, 2'h2, 1'b0, 1'b1);
         chk("running", 12'h000, {11'h000, burst_running});
         chk("banks", 12'h010, bank_state);
         issue(`CMD_WRITE, 2'h1, 1'b0, 1'b1);
         chk("banks", 12'h020, bank_state);
         issue(`CMD_PRE, 2'h1, 1'b0, 1'b1);
         chk("banks", 12'h038, bank_state);
         @(negedge clock);
         chk("banks", 12'h000, bank_state);
         idle_inhibit = 1'b0;
         $display("row test done");
      end
   endtask

   task t_misc;
      begin
         issue(`CMD_READ, 2'h0, 1'b0, 1'b1);
         chk("refuse", 12'h001, {11'h000, cmd_refused});
         issue(`CMD_PRE, 2'h0, 1'b0, 1'b1);
         chk("accept", 12'h001, {11'h000, cmd_accepted});
         chk("banks", 12'h000, bank_state);
         issue(`CMD_REFRESH, 2'h0, 1'b0, 1'b1);
         chk("global", 12'h001, {9'h000, global_state});
         chk("idle", 12'h001, {11'h000, all_banks_idle});
         @(negedge clock);
         chk("global", 12'h000, {9'h000, global_state});
         chk("idle", 12'h000, {11'h000, all_banks_idle});
         issue(`CMD_LOADMODE, 2'h0, 1'b0, 1'b1);
         chk("global", 12'h002, {9'h000, global_state});
         @(negedge clock);
         chk("global", 12'h000, {9'h000, global_state});
         $display("misc test done");
      end
   endtask

   task t_power;
      begin
         issue(`CMD_NOP, 2'h0, 1'b0, 1'b0);
         chk("global", 12'h004, {9'h000, global_state});
         issue(`CMD_ACTIVE, 2'h0, 1'b0, 1'b0);
         chk("global", 12'h004, {9'h000, global_state});
         chk("banks", 12'h000, bank_state);
         issue(`CMD_NOP, 2'h0, 1'b0, 1'b1);
         chk("global", 12'h000, {9'h000, global_state});
         issue(`CMD_REFRESH, 2'h0, 1'b0, 1'b0);
         chk("global", 12'h005, {9'h000, global_state});
         issue(`CMD_NOP, 2'h0, 1'b0, 1'b1);
         chk("global", 12'h006, {9'h000, global_state});
         @(negedge clock);
         chk("global", 12'h000, {9'h000, global_state});
         $display("power test done");
      end
   endtask

   task t_suspend;
      begin
         issue(`CMD_ACTIVE, 2'h2, 1'b0, 1'b1);
         @(negedge clock);
         issue(`CMD_WRITE, 2'h2, 1'b0, 1'b1);
         chk("banks", 12'h100, bank_state);
         issue(`CMD_WRITE, 2'h2, 1'b1, 1'b0);
         chk("banks", 12'h180, bank_state);
         chk("global", 12'h007, {9'h000, global_state});
         chk("run", 12'h000, {11'h000, internal_clock_run});
         issue(`CMD_READ, 2'h0, 1'b0, 1'b0);
         chk("banks", 12'h180, bank_state);
         // Exit, then a command on the very next edge
         @(negedge clock);
         req_cke = 1'b1;
         @(negedge clock);
         req = 1'b1;
         req_cmd = `CMD_ACTIVE;
         req_ba = 2'h0;
         req_a10 = 1'b0;
         @(negedge clock);
         req = 1'b0;
         chk("global", 12'h000, {9'h000, global_state});
         @(negedge clock);
         chk("bank0", 12'h001, {9'h000, bank_state[2:0]});
         chk("accept", 12'h001, {11'h000, cmd_accepted});
         repeat (10) @(negedge clock);
         chk("banks", 12'h002, bank_state);
         issue(`CMD_PRE, 2'h0, 1'b1, 1'b1);
         chk("global", 12'h003, {9'h000, global_state});
         chk("banks", 12'h007, bank_state);
         @(negedge clock);
         chk("global", 12'h000, {9'h000, global_state});
         chk("banks", 12'h000, bank_state);
         $display("suspend test done");
      end
   endtask

   // Main sequence
   initial begin
      repeat (3) @(negedge clock);
      chk("banks", 12'h000, bank_state);
      chk("idle", 12'h001, {11'h000, all_banks_idle});
      chk("run", 12'h001, {11'h000, internal_clock_run});
      repeat (9) @(negedge clock);
      sys_rst = 1'b0;
      t_row;
      t_misc;
      t_power;
      t_suspend;
      tally_and_finish;
   end
endmodule // tb_top
